// ===== core/ssb_dummy_unused.sv
`timescale 1ns/10ps

// ===== core/ssb_pkg.sv
// Constants and carrier types of the serial slave with select and buffering.
// Assumes a 32-bit classic Wishbone register bus, one register to an aligned word.
package ssb_pkg;

  // ****************************************
  // Register indices and byte addresses
  // ****************************************
  localparam logic [2:0] IDX_CTRLA    = 3'h0;
  localparam logic [2:0] IDX_CONTROL_B_REG    = 3'h1;
  localparam logic [2:0] IDX_IRQ_EN   = 3'h2;
  localparam logic [2:0] IDX_IRQ_FLAG = 3'h3;
  localparam logic [2:0] IDX_DATA     = 3'h4;
  localparam logic [2:0] IDX_PORT     = 3'h5;
  localparam int         ADR_W        = 8;
  localparam logic [ADR_W-1:0] A_CTRLA    = {3'h0, IDX_CTRLA, 2'h0};
  localparam logic [ADR_W-1:0] A_CONTROL_B_REG    = {3'h0, IDX_CONTROL_B_REG, 2'h0};
  localparam logic [ADR_W-1:0] A_IRQ_EN   = {3'h0, IDX_IRQ_EN, 2'h0};
  localparam logic [ADR_W-1:0] A_IRQ_FLAG = {3'h0, IDX_IRQ_FLAG, 2'h0};
  localparam logic [ADR_W-1:0] A_DATA     = {3'h0, IDX_DATA, 2'h0};
  localparam logic [ADR_W-1:0] A_PORT     = {3'h0, IDX_PORT, 2'h0};

  // ****************************************
  // Field positions and reset values
  // ****************************************
  localparam int B_ENABLE  = 0;
  localparam int B_MASTER  = 5;
  localparam int B_ORDER   = 6;
  localparam int B_MODE_LO = 0;
  localparam int B_BUFFER_ENABLE   = 7;
  localparam int B_WFR     = 6;
  localparam int B_RXC     = 7;
  localparam int B_TXC     = 6;
  localparam int B_DRE     = 5;
  localparam int B_SSI     = 4;
  localparam int B_IE      = 0;
  localparam int B_OVF     = 0;
  localparam int B_MISO_OUT = 0;
  localparam int B_DEEP     = 1;
  localparam logic [7:0] CTRLA_MASK = 8'h71;
  localparam logic [7:0] CONTROL_B_REG_MASK = 8'hC7;
  localparam logic [7:0] IRQEN_MASK = 8'hF1;
  localparam logic [7:0] PORT_MASK  = 8'h03;
  localparam logic [7:0] RST_BYTE   = 8'h00;
  localparam logic [2:0] LAST_BIT   = 3'h7;
  localparam logic [1:0] RX_DEPTH   = 2'h2;

  // Synchronised pin levels
  typedef struct packed {
    logic sck;
    logic mosi;
    logic ss_n;
  } ssb_pins_t;

endpackage

// ===== core/ssb_rxfifo.sv
// Receive queue of up to two bytes; depth one in unbuffered operation.
// Assumes push and pop come from the same clock; a push when full is dropped unless a pop comes in the same cycle.
`timescale 1ns/10ps
module ssb_rxfifo
  import ssb_pkg::*;
(
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // Control
  input  wire logic       two_deep,
  input  wire logic       push,
  input  wire logic [7:0] din,
  input  wire logic       pop,
  // Status
  output logic      [7:0] dout,
  output logic            ovf
);

  logic [7:0] mem [2];
  logic       rd_q;
  logic [1:0] cnt_q;
  logic       full;
  logic       do_pop;
  logic       do_push;

  assign full    = two_deep ? (cnt_q >= RX_DEPTH) : (cnt_q != 2'h0);
  assign do_pop  = pop && (cnt_q != 2'h0);
  assign do_push = push && (!full || do_pop);
  assign ovf     = push && full && !do_pop;
  assign dout    = (cnt_q == 2'h0) ? RST_BYTE : mem[rd_q];

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      rd_q  <= 1'b0;
      cnt_q <= 2'h0;
    end
    else
    begin
      if (do_pop)
        rd_q <= ~rd_q;
      cnt_q <= cnt_q + 2'(do_push) - 2'(do_pop);
    end
  end

  always_ff @(posedge clk)
  begin
    if (do_push)
      mem[rd_q ^ cnt_q[0]] <= din;
  end

endmodule // ssb_rxfifo

// ===== core/ssb_slave.sv
// Serial slave with select handling, MISO drive and buffered transmit.
// Assumes REF_CLK at 25 MHz samples SCK; SCK phases exceed two REF_CLK cycles.
// Overview of operation
// - Select, data-in and clock are always inputs
// - Select low: shift out if MISO direction out
// - Select high: idle, MISO released
// - Select rising aborts transfer, clears bit counter
// - Unbuffered: idle while deselected, loads allowed
// - Unbuffered: loaded byte shifts from first pulse
// - Unbuffered: done flag after eight bits
// - Unbuffered: early write dropped, collision flagged
// - Buffer-enable selects buffering; wait bit sub-mode
// - Buffered: data writes fill transmit buffer
// - No wait: dummy first, buffer moves after
// - Wait: deselected write loads shifter next cycle
// - Buffered: write to full buffer dropped
// - Empty flag clears on write, sets on move
// - Receive flag one cycle after empty flag
// - Transfer flag one later when all sent
// - Four clock modes; sample, change opposite edges
// - Leading edge first, trailing edge last
// - Buffered: four flags share one interrupt line; unbuffered: receive only
// - Request while enabled flag stays set
// - Idle sleep runs; deeper sleep aborts transfer
// - Mode field sets leading polarity, sample edge
// - Bit order: zero MSB first, one LSB
`timescale 1ns/10ps
module ssb_slave
  import ssb_pkg::*;
(
  // Clock and reset
  input  wire logic             REF_CLK,
  input  wire logic             RESET_N,
  // Wishbone slave
  input  wire logic             WB_CYC_I,
  input  wire logic             WB_STB_I,
  input  wire logic             WB_WE_I,
  input  wire logic [ADR_W-1:0] WB_ADR_I,
  input  wire logic [3:0]       WB_SEL_I,
  input  wire logic [31:0]      WB_DAT_I,
  output logic      [31:0]      WB_DAT_O,
  output logic                  WB_ACK_O,
  // Serial pins
  input  wire logic             SCK,
  input  wire logic             MOSI,
  input  wire logic             SS_N,
  output logic                  MISO_O,
  output logic                  MISO_OE_N,
  // Interrupt request
  output logic                  IRQ
);

  // ****************************************
  // Pin synchronisation
  // ****************************************
  ssb_pins_t pins_raw;
  ssb_pins_t pins;

  assign pins_raw = '{sck: SCK, mosi: MOSI, ss_n: SS_N};

  ssb_sync #(.W(3)) u_sync (
    .clk   (REF_CLK),
    .rst_n (RESET_N),
    .din   (pins_raw),
    .dout  (pins)
  );

  // ****************************************
  // Bus slave
  // ****************************************
  logic [7:0] ctrla_q;
  logic [7:0] control_b_reg_q;
  logic [7:0] irq_en_q;
  logic [7:0] port_q;
  logic       ack_q;
  logic [7:0] rdat_q;
  logic [7:0] rdat_d;
  logic       acc;
  logic       wr;
  logic       rd;
  logic [7:0] wdat;
  logic       wr_data;
  logic       rd_data;
  logic       wr_flag;

  assign acc     = WB_CYC_I && WB_STB_I && ack_q;
  assign wr      = acc && WB_WE_I && WB_SEL_I[0];
  assign rd      = acc && !WB_WE_I;
  assign wdat    = WB_DAT_I[7:0];
  assign wr_data = wr && (WB_ADR_I == A_DATA);
  assign rd_data = rd && (WB_ADR_I == A_DATA);
  assign wr_flag = wr && (WB_ADR_I == A_IRQ_FLAG);

  always_ff @(posedge REF_CLK)
  begin
    if (!RESET_N)
      ack_q <= 1'b0;
    else
      ack_q <= WB_CYC_I && WB_STB_I && !ack_q;
  end

  always_ff @(posedge REF_CLK)
  begin
    if (!RESET_N)
    begin
      ctrla_q  <= RST_BYTE;
      control_b_reg_q  <= RST_BYTE;
      irq_en_q <= RST_BYTE;
      port_q   <= RST_BYTE;
    end
    else if (wr)
    begin
      if (WB_ADR_I == A_CTRLA)
        ctrla_q <= wdat & CTRLA_MASK;
      else if (WB_ADR_I == A_CONTROL_B_REG)
        control_b_reg_q <= wdat & CONTROL_B_REG_MASK;
      else if (WB_ADR_I == A_IRQ_EN)
        irq_en_q <= wdat & IRQEN_MASK;
      else if (WB_ADR_I == A_PORT)
        port_q <= wdat & PORT_MASK;
    end
  end

  // ****************************************
  // Clock edges and modes
  // ****************************************
  logic       enable;
  logic       buffered;
  logic       wait_for_receive;
  logic       bit_order;
  logic       deep_sleep;
  logic       run;
  logic       sck_prev_q;
  logic       ss_prev_q;
  logic       rise;
  logic       fall;
  logic       lead;
  logic       trail;
  logic       samp;
  logic       setup;

  assign enable           = ctrla_q[B_ENABLE];
  assign bit_order        = ctrla_q[B_ORDER];
  assign buffered         = control_b_reg_q[B_BUFFER_ENABLE];
  assign wait_for_receive = control_b_reg_q[B_WFR];
  assign deep_sleep       = port_q[B_DEEP];
  assign run   = enable && !deep_sleep && !pins.ss_n;
  assign rise  = pins.sck && !sck_prev_q;
  assign fall  = !pins.sck && sck_prev_q;
  assign lead  = control_b_reg_q[B_MODE_LO + 1] ? fall : rise;
  assign trail = control_b_reg_q[B_MODE_LO + 1] ? rise : fall;
  assign samp  = control_b_reg_q[B_MODE_LO] ? trail : lead;
  assign setup = control_b_reg_q[B_MODE_LO] ? lead : trail;

  always_ff @(posedge REF_CLK)
  begin
    if (!RESET_N)
    begin
      sck_prev_q <= 1'b1;
      ss_prev_q  <= 1'b1;
    end
    else
    begin
      sck_prev_q <= pins.sck;
      ss_prev_q  <= pins.ss_n;
    end
  end

  // ****************************************
  // Bit counter and shift register
  // ****************************************
  logic [2:0] cnt_q;
  logic       busy_q;
  logic [7:0] sh_q;
  logic [7:0] shifted;
  logic       xfer_end;
  logic       tbuf_full_q;
  logic [7:0] tbuf_q;
  logic       sh_loaded_q;
  logic       norm_load;
  logic       wfr_load;
  logic       end_move;
  logic       out_bit;

  assign shifted  = bit_order ? {pins.mosi, sh_q[7:1]} : {sh_q[6:0], pins.mosi};
  assign out_bit  = bit_order ? sh_q[0] : sh_q[7];
  assign xfer_end = run && samp && (cnt_q == LAST_BIT);
  assign norm_load = !buffered && wr_data && !busy_q;
  assign wfr_load  = buffered && wait_for_receive && pins.ss_n && tbuf_full_q
                     && !sh_loaded_q;
  assign end_move  = buffered && xfer_end && tbuf_full_q;

  always_ff @(posedge REF_CLK)
  begin
    if (!RESET_N)
    begin
      cnt_q  <= 3'h0;
      busy_q <= 1'b0;
    end
    else if (!run)
    begin
      cnt_q  <= 3'h0;
      busy_q <= 1'b0;
    end
    else if (samp)
    begin
      cnt_q  <= cnt_q + 3'h1;
      busy_q <= (cnt_q != LAST_BIT);
    end
  end

  always_ff @(posedge REF_CLK)
  begin
    if (!RESET_N)
      sh_q <= RST_BYTE;
    else if (run && samp)
    begin
      if (end_move)
        sh_q <= tbuf_q;
      else
        sh_q <= shifted;
    end
    else if (norm_load)
      sh_q <= wdat;
    else if (wfr_load)
      sh_q <= tbuf_q;
  end

  always_ff @(posedge REF_CLK)
  begin
    if (!RESET_N)
      sh_loaded_q <= 1'b0;
    else if (norm_load || wfr_load || end_move)
      sh_loaded_q <= 1'b1;
    else if (xfer_end)
      sh_loaded_q <= 1'b0;
  end

  // ****************************************
  // Transmit buffer
  // ****************************************
  always_ff @(posedge REF_CLK)
  begin
    if (!RESET_N)
    begin
      tbuf_q      <= RST_BYTE;
      tbuf_full_q <= 1'b0;
    end
    else if (buffered && wr_data && !tbuf_full_q)
    begin
      tbuf_q      <= wdat;
      tbuf_full_q <= 1'b1;
    end
    else if (end_move || wfr_load)
      tbuf_full_q <= 1'b0;
  end

  // ****************************************
  // MISO drive
  // ****************************************
  always_ff @(posedge REF_CLK)
  begin
    if (!RESET_N)
    begin
      MISO_O    <= 1'b0;
      MISO_OE_N <= 1'b1;
    end
    else
    begin
      MISO_OE_N <= !(run && port_q[B_MISO_OUT]);
      if (!run || setup)
        MISO_O <= out_bit;
    end
  end

  // ****************************************
  // Receive path
  // ****************************************
  logic [7:0] rx_head;
  logic       rx_ovf;

  ssb_rxfifo u_rx (
    .clk      (REF_CLK),
    .rst_n    (RESET_N),
    .two_deep (buffered),
    .push     (xfer_end),
    .din      (shifted),
    .pop      (rd_data),
    .dout     (rx_head),
    .ovf      (rx_ovf)
  );

  // ****************************************
  // Flags and interrupt request
  // ****************************************
  logic       end_d1_q;
  logic       end_d2_q;
  logic [7:0] flag_q;
  logic [7:0] set_v;
  logic [7:0] clr_v;

  always_ff @(posedge REF_CLK)
  begin
    if (!RESET_N)
    begin
      end_d1_q <= 1'b0;
      end_d2_q <= 1'b0;
    end
    else
    begin
      end_d1_q <= xfer_end && buffered;
      end_d2_q <= end_d1_q;
    end
  end

  always_comb
  begin
    set_v        = 8'h00;
    set_v[B_RXC] = buffered ? end_d1_q : xfer_end;
    set_v[B_TXC] = buffered ? (end_d2_q && !sh_loaded_q && !tbuf_full_q)
                            : (wr_data && busy_q);
    set_v[B_DRE] = end_move || wfr_load;
    set_v[B_SSI] = buffered && enable && ss_prev_q && !pins.ss_n;
    set_v[B_OVF] = rx_ovf;
    clr_v        = wr_flag ? wdat : 8'h00;
    clr_v[B_DRE] = clr_v[B_DRE] || (buffered && wr_data && !tbuf_full_q);
  end

  always_ff @(posedge REF_CLK)
  begin
    if (!RESET_N)
      flag_q <= RST_BYTE;
    else
      flag_q <= set_v | (flag_q & ~clr_v);
  end

  always_ff @(posedge REF_CLK)
  begin
    if (!RESET_N)
      IRQ <= 1'b0;
    else if (buffered)
      IRQ <= |(flag_q[B_RXC:B_SSI] & irq_en_q[B_RXC:B_SSI]);
    else
      IRQ <= flag_q[B_RXC] && irq_en_q[B_IE];
  end

  // ****************************************
  // Read data
  // ****************************************
  always_comb
  begin
    rdat_d = RST_BYTE;
    if (WB_ADR_I == A_CTRLA)
      rdat_d = ctrla_q;
    else if (WB_ADR_I == A_CONTROL_B_REG)
      rdat_d = control_b_reg_q;
    else if (WB_ADR_I == A_IRQ_EN)
      rdat_d = irq_en_q;
    else if (WB_ADR_I == A_IRQ_FLAG)
      rdat_d = flag_q;
    else if (WB_ADR_I == A_DATA)
      rdat_d = rx_head;
    else if (WB_ADR_I == A_PORT)
      rdat_d = port_q;
  end

  always_ff @(posedge REF_CLK)
  begin
    if (!RESET_N)
      rdat_q <= RST_BYTE;
    else if (WB_CYC_I && WB_STB_I && !ack_q)
      rdat_q <= rdat_d;
  end

  assign WB_ACK_O = ack_q;
  assign WB_DAT_O = {24'h000000, rdat_q};

endmodule // ssb_slave

// ===== core/ssb_sync.sv
// Three-stage synchroniser with agreement filter for pin inputs.
// Assumes inputs are asynchronous to clk; output changes once stages two and three agree.
`timescale 1ns/10ps
module ssb_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  // Levels
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);

  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;
  logic [W-1:0] f_q;

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      s1_q <= '1;
      s2_q <= '1;
      s3_q <= '1;
      f_q  <= '1;
    end
    else
    begin
      s1_q <= din;
      s2_q <= s1_q;
      s3_q <= s2_q;
      for (int i = 0; i < W; i++)
      begin
        if (s2_q[i] == s3_q[i])
          f_q[i] <= s3_q[i];
      end
    end
  end

  assign dout = f_q;

endmodule // ssb_sync

// ===== dv/ssb_master_model.sv
// Behavioural serial master facing the slave.
// Assumes clk is the bench clock; one serial clock period is eight clk cycles.
`timescale 1ns/10ps
module ssb_master_model (
  // Clock
  input  wire logic clk,
  // Serial pins
  input  wire logic miso,
  output logic      sck,
  output logic      mosi,
  output logic      ss_n
);
  initial
  begin
    sck  <= 1'b0;
    mosi <= 1'b0;
    ss_n <= 1'b1;
  end

  // ****************************************
  // Select and shift tasks
  // ****************************************
  task automatic sel(input logic on, input logic [1:0] mode);
    @(posedge clk);
    if (!on)
    begin
      sck  <= mode[1];
      mosi <= ~mosi;
    end
    ss_n <= ~on;
    repeat (8) @(posedge clk);
  endtask

  // Sampling late in the phase tolerates the slave's synchroniser lag
  task automatic xfer(input logic [7:0] tx, input int nbits, input logic [1:0] mode,
                      input logic lsb, output logic [7:0] rx);
    int i;
    int b;
    rx = 8'h00;
    for (i = 0; i < nbits; i++)
    begin
      b = lsb ? i : 7 - i;
      mosi <= tx[b];
      if (mode[0])
        sck <= ~mode[1];
      repeat (4) @(posedge clk);
      sck <= mode[0] ? mode[1] : ~mode[1];
      repeat (3) @(posedge clk);
      rx[b] = miso;
      @(posedge clk);
      if (!mode[0])
        sck <= mode[1];
    end
  endtask
endmodule // ssb_master_model

// ===== dv/ssb_slave_assertions.sv
// Checker on the top ports of the serial slave.
// Assumes it is bound into ssb_slave; internal flags are not visible.
`timescale 1ns/10ps
module ssb_slave_chk (
  // Clock and reset
  input wire logic        REF_CLK,
  input wire logic        RESET_N,
  // Register bus
  input wire logic        WB_CYC_I,
  input wire logic        WB_STB_I,
  input wire logic [31:0] WB_DAT_O,
  input wire logic        WB_ACK_O,
  // Serial pins and request
  input wire logic        SS_N,
  input wire logic        MISO_OE_N,
  input wire logic        IRQ
);
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RESET_N);

  // ****************************************
  // Bus and pin properties
  // ****************************************
  a_ack_one_cycle: assert property (WB_ACK_O |=> !WB_ACK_O)
    else $error("ack held longer than one cycle");
  a_ack_next_edge: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O)
    else $error("ack missing one cycle after request");
  a_ack_has_cause: assert property ($rose(WB_ACK_O) |-> $past(WB_CYC_I && WB_STB_I))
    else $error("ack without request");
  a_rdat_high_zero: assert property (WB_ACK_O |-> WB_DAT_O[31:8] == 24'h000000)
    else $error("read data upper bits not zero");
  a_rdat_held: assert property (!(WB_CYC_I && WB_STB_I) |=> $stable(WB_DAT_O))
    else $error("read data changed between accesses");
  a_miso_released: assert property (SS_N [*6] |-> MISO_OE_N)
    else $error("data out driven while deselected");
  a_drop_on_rise: assert property ($rose(SS_N) |-> ##[1:8] MISO_OE_N)
    else $error("data out not released after deselect");
  a_drive_selected: assert property ($fell(MISO_OE_N) |-> $past(!SS_N, 2))
    else $error("data out driven without select");

  c_read_ack: cover property (WB_ACK_O && WB_DAT_O[7:0] != 8'h00);
  c_drive: cover property ($fell(MISO_OE_N));
  c_irq: cover property ($rose(IRQ));
endmodule // ssb_slave_chk

bind ssb_slave ssb_slave_chk ssb_slave_chk_inst (.REF_CLK, .RESET_N, .WB_CYC_I, .WB_STB_I,
  .WB_DAT_O, .WB_ACK_O, .SS_N, .MISO_OE_N, .IRQ);

// ===== dv/testbench.sv
// Self-checking bench: registers, serial transfers, flags and request line.
// Assumes the package, slave, master model and bound checker are compiled first.
`timescale 1ns/10ps
module testbench
  import ssb_pkg::*;
;
  logic             REF_CLK;
  logic             RESET_N;
  logic             WB_CYC_I;
  logic             WB_STB_I;
  logic             WB_WE_I;
  logic [ADR_W-1:0] WB_ADR_I;
  logic [3:0]       WB_SEL_I;
  logic [31:0]      WB_DAT_I;
  logic [31:0]      WB_DAT_O;
  logic             WB_ACK_O;
  logic             SCK;
  logic             MOSI;
  logic             SS_N;
  logic             MISO_O;
  logic             MISO_OE_N;
  logic             IRQ;
  wire              miso_w;
  int               bad_count;
  int               cmp_count;
  int               i;
  logic [7:0]       exq[$];
  logic [7:0]       rx;
  logic [7:0]       tx;
  logic [7:0]       mo;
  localparam logic [ADR_W-1:0] ADS [5] = '{A_CTRLA, A_CONTROL_B_REG, A_IRQ_EN, A_PORT, 8'h40};
  localparam logic [7:0]       MSK [5] = '{CTRLA_MASK, CONTROL_B_REG_MASK, IRQEN_MASK, PORT_MASK, 8'h00};

  initial REF_CLK = 1'b0;
  always #20 REF_CLK = ~REF_CLK;
  // Released line shows the inverse so a late sample cannot pass by luck
  assign miso_w = MISO_OE_N ? ~MISO_O : MISO_O;

  ssb_slave ssb_slave_inst (.REF_CLK, .RESET_N, .WB_CYC_I, .WB_STB_I, .WB_WE_I, .WB_ADR_I,
    .WB_SEL_I, .WB_DAT_I, .WB_DAT_O, .WB_ACK_O, .SCK, .MOSI, .SS_N, .MISO_O, .MISO_OE_N, .IRQ);
  ssb_master_model ssb_master_model_inst (.clk(REF_CLK), .miso(miso_w), .sck(SCK), .mosi(MOSI),
    .ss_n(SS_N));

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("CHECK FAILED at %0t: got %h want %h", $time, seen, exp);
    end
  endtask

  task automatic wrap_up();
    $display("Mismatches %0d of %0d comparisons", bad_count, cmp_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic wb(input logic we, input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    WB_CYC_I <= 1'b1;
    WB_STB_I <= 1'b1;
    WB_WE_I  <= we;
    WB_ADR_I <= a;
    WB_DAT_I <= {24'h000000, d};
    do
    begin
      @(posedge REF_CLK);
      n++;
    end
    while (WB_ACK_O !== 1'b1 && n < 20);
    if (WB_ACK_O !== 1'b1)
    begin
      bad_count++;
      wrap_up();
    end
    else
    begin
      WB_CYC_I <= 1'b0;
      WB_STB_I <= 1'b0;
      @(posedge REF_CLK);
    end
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    exq.push_back(exp);
    wb(1'b0, a, 8'h00);
  endtask

  // One full byte: data seen by the master, flags, request, received byte
  task automatic bx(input logic [1:0] m, input logic lsb, input logic [7:0] want,
                    input logic [7:0] flags, input logic irq_e);
    logic [7:0] got;
    logic [7:0] t;
    t = 8'($urandom);
    ssb_master_model_inst.sel(1'b1, m);
    ssb_master_model_inst.xfer(t, 8, m, lsb, got);
    ssb_master_model_inst.sel(1'b0, m);
    chk(got, want);
    rd(A_IRQ_FLAG, flags);
    chk({7'h00, IRQ}, {7'h00, irq_e});
    wb(1'b1, A_IRQ_FLAG, 8'hFF);
    rd(A_DATA, t);
    chk({7'h00, IRQ}, 8'h00);
    mo = t;
  endtask

  always @(posedge REF_CLK)
    if (WB_ACK_O === 1'b1 && !WB_WE_I)
      chk(WB_DAT_O[7:0], exq.pop_front());

  initial
  begin
    repeat (60000) @(posedge REF_CLK);
    bad_count++;
    wrap_up();
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial
  begin
    bad_count = 0;
    cmp_count = 0;
    RESET_N  <= 1'b0;
    WB_CYC_I <= 1'b0;
    WB_STB_I <= 1'b0;
    WB_WE_I  <= 1'b0;
    WB_ADR_I <= 8'h00;
    WB_SEL_I <= 4'hF;
    WB_DAT_I <= 32'h00000000;
    tx = 8'($urandom(32'hA2012320));
    repeat (4) @(posedge REF_CLK);
    RESET_N <= 1'b1;
    @(posedge REF_CLK);
    rd(A_IRQ_FLAG, RST_BYTE);
    for (i = 0; i < 5; i++)
    begin
      tx = 8'($urandom);
      rd(ADS[i], RST_BYTE);
      wb(1'b1, ADS[i], tx);
      rd(ADS[i], tx & MSK[i]);
      wb(1'b1, ADS[i], 8'h00);
    end
    wb(1'b1, A_PORT, 8'h01);
    for (i = 0; i < 8; i++)
    begin
      ssb_master_model_inst.sel(1'b0, 2'(i));
      wb(1'b1, A_CTRLA, {1'b0, i[2], 6'h01});
      wb(1'b1, A_CONTROL_B_REG, {6'h00, 2'(i)});
      wb(1'b1, A_IRQ_EN, {7'h00, i[0]});
      tx = 8'($urandom);
      wb(1'b1, A_DATA, tx);
      bx(2'(i), i[2], tx, 8'h80, i[0]);
    end
    wb(1'b1, A_CTRLA, 8'h01);
    wb(1'b1, A_CONTROL_B_REG, 8'h00);
    ssb_master_model_inst.sel(1'b0, 2'h0);
    wb(1'b1, A_DATA, 8'hA5);
    fork
      bx(2'h0, 1'b0, 8'hA5, 8'hC0, 1'b1);
      begin
        repeat (40) @(posedge REF_CLK);
        wb(1'b1, A_DATA, 8'h3C);
      end
    join
    wb(1'b1, A_DATA, 8'hF0);
    ssb_master_model_inst.sel(1'b1, 2'h0);
    chk({7'h00, MISO_OE_N}, 8'h00);
    ssb_master_model_inst.xfer(8'hFF, 4, 2'h0, 1'b0, rx);
    ssb_master_model_inst.sel(1'b0, 2'h0);
    chk({7'h00, MISO_OE_N}, 8'h01);
    rd(A_IRQ_FLAG, 8'h00);
    wb(1'b1, A_DATA, 8'h96);
    bx(2'h0, 1'b0, 8'h96, 8'h80, 1'b1);
    wb(1'b1, A_PORT, 8'h03);
    ssb_master_model_inst.sel(1'b1, 2'h0);
    ssb_master_model_inst.xfer(8'h5A, 8, 2'h0, 1'b0, rx);
    ssb_master_model_inst.sel(1'b0, 2'h0);
    rd(A_IRQ_FLAG, 8'h00);
    wb(1'b1, A_PORT, 8'h01);
    wb(1'b1, A_IRQ_EN, 8'h80);
    wb(1'b1, A_CONTROL_B_REG, 8'h80);
    wb(1'b1, A_DATA, 8'h43);
    bx(2'h0, 1'b0, mo, 8'hB0, 1'b1);
    wb(1'b1, A_DATA, 8'h44);
    wb(1'b1, A_DATA, 8'h45);
    rd(A_IRQ_FLAG, 8'h00);
    bx(2'h0, 1'b0, 8'h43, 8'hB0, 1'b1);
    bx(2'h0, 1'b0, 8'h44, 8'hD0, 1'b1);
    wb(1'b1, A_CONTROL_B_REG, 8'hC0);
    wb(1'b1, A_DATA, 8'h43);
    rd(A_IRQ_FLAG, 8'h20);
    wb(1'b1, A_DATA, 8'h44);
    rd(A_IRQ_FLAG, 8'h00);
    bx(2'h0, 1'b0, 8'h43, 8'hB0, 1'b1);
    bx(2'h0, 1'b0, 8'h44, 8'hD0, 1'b1);
    wrap_up();
  end
endmodule // testbench
